// File: shared/gtr_cfg.svh
`ifndef GTR_CFG_SVH
`define GTR_CFG_SVH

// Register byte offsets on the bus
`define GTR_OFS_COUNT     8'h00
`define GTR_OFS_PERIOD    8'h04
`define GTR_OFS_CONTROL   8'h08
`define GTR_OFS_OSC_CTRL  8'h0c
`define GTR_OFS_IRQ_STAT  8'h10
`define GTR_OFS_IRQ_MASK  8'h14

// Control word bit positions
`define GTR_BIT_RUN       15
`define GTR_BIT_IDLE_STOP 13
`define GTR_BIT_GATE      6
`define GTR_BIT_PSC_HI    5
`define GTR_BIT_PSC_LO    4
`define GTR_BIT_SYNC      2
`define GTR_BIT_CLK_SRC   1

// Oscillator control bit position
`define GTR_BIT_LPOSC     1

// Interrupt status and mask bit positions
`define GTR_IRQ_PERIOD    0
`define GTR_IRQ_GATE      1
`define GTR_IRQ_WAKE      2
`define GTR_IRQ_W         3

// Reset values
`define GTR_RST_COUNT     16'h0000
`define GTR_RST_PERIOD    16'hffff
`define GTR_RST_CONTROL   16'h0000

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GTR_PSC_LAST_1    8'h00
`define GTR_PSC_LAST_8    8'h07
`define GTR_PSC_LAST_64   8'h3f
`define GTR_PSC_LAST_256  8'hff

// Bus responses
`define GTR_RESP_OKAY     2'b00
`define GTR_RESP_SLVERR   2'b10

`endif

// File: shared/gtr_pkg.sv
package gtr_pkg;

  typedef enum logic [5:0] {
    GTR_MODE_OFF   = 6'b000001,
    GTR_MODE_TIMER = 6'b000010,
    GTR_MODE_GATED = 6'b000100,
    GTR_MODE_SYNC  = 6'b001000,
    GTR_MODE_ASYNC = 6'b010000,
    GTR_MODE_RTC   = 6'b100000
  } gtr_mode_e;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic        run;
    logic        idle_stop;
    logic        gate_en;
    logic [1:0]  psc_sel;
    logic        sync_sel;
    logic        clk_src;
    logic        lposc_en;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [7:0]  psc;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        ext_prev;
    logic        lp_prev;
    logic        gate_prev;
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
  } gtr_state_s;

endpackage

// File: verilog/gtr_timer.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
// Behaviour
// RL1: Internal mode counts every cycle up to period, then wraps to zero.
// RL2: Idle halts counting when idle stop bit set; otherwise counting continues.
// RL3: Synchronous mode synchronises external clock, counts rising edges, wraps at period.
// RL4: Asynchronous mode counts raw external rising edges; idle stops it only if bit set.
// RL5: Gated mode counts cycles only while gate pin high.
// RL6: Gate falling edge raises interrupt flag, count kept.
// RL7: Selected clock divided by 1, 8, 64 or 256.
// RL8: Prescaler cleared on count write, run bit clear, reset; held while off.
// RL9: Control word write leaves count untouched; only count write changes it.
// RL10: Sleep counting only with run on, external clock, sync select zero.
// RL11: Period match sets sticky flag; hardware never clears it.
// RL12: Interrupt reaches processor only when enable bit set, any mode.
// RL13: RTC mode counts low-power oscillator edges up to period, then zero.
// RL14: Software keeps sync select zero for real-time-clock use.
// RL15: Low-power oscillator enable disables normal modes, adds carry-out wake event.
// RL16: RTC keeps counting through sleep while oscillator runs.
// RL17: Prescale select 00, 01, 10, 11 means 1, 8, 64, 256.
`include "gtr_cfg.svh"

module gtr_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gate_clock_pin,
  input  wire logic        lp_osc_in,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             irq,
  output logic             wake_event
);

  gtr_pkg::gtr_state_s s_q;
  gtr_pkg::gtr_state_s s_d;
  gtr_pkg::gtr_mode_e  mode;

  logic        run_ok;
  logic        inc;
  logic        tick;
  logic        match;
  logic        wr_en;
  logic        rd_en;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic [15:0] ctrl_word;

  // RL17: prescale encoding
  function automatic logic [7:0] psc_last(input logic [1:0] sel);
    case (sel)
      2'b00:   psc_last = `GTR_PSC_LAST_1;
      2'b01:   psc_last = `GTR_PSC_LAST_8;
      2'b10:   psc_last = `GTR_PSC_LAST_64;
      default: psc_last = `GTR_PSC_LAST_256;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  always_comb begin
    ctrl_word                     = 16'h0000;
    ctrl_word[`GTR_BIT_RUN]       = s_q.run;
    ctrl_word[`GTR_BIT_IDLE_STOP] = s_q.idle_stop;
    ctrl_word[`GTR_BIT_GATE]      = s_q.gate_en;
    ctrl_word[`GTR_BIT_PSC_HI]    = s_q.psc_sel[1];
    ctrl_word[`GTR_BIT_PSC_LO]    = s_q.psc_sel[0];
    ctrl_word[`GTR_BIT_SYNC]      = s_q.sync_sel;
    ctrl_word[`GTR_BIT_CLK_SRC]   = s_q.clk_src;
  end

  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign irq           = s_q.irq;
  assign wake_event    = s_q.wake;

  assign wr_en = s_q.aw_ok && s_q.w_ok;
  assign rd_en = s_axi_arvalid && !s_q.rvalid;

  // Mode select; low-power oscillator overrides the normal modes
  always_comb begin
    if (!s_q.run) begin
      mode = gtr_pkg::GTR_MODE_OFF;
    end else if (s_q.lposc_en) begin
      // RL15: normal modes disabled
      // RL13: oscillator counted when external clock selected, gate off
      if (s_q.clk_src && !s_q.gate_en) begin
        mode = gtr_pkg::GTR_MODE_RTC;
      end else begin
        mode = gtr_pkg::GTR_MODE_OFF;
      end
    end else if (!s_q.clk_src) begin
      mode = s_q.gate_en ? gtr_pkg::GTR_MODE_GATED : gtr_pkg::GTR_MODE_TIMER;
    end else begin
      mode = s_q.sync_sel ? gtr_pkg::GTR_MODE_SYNC : gtr_pkg::GTR_MODE_ASYNC;
    end
  end

  always_comb begin
    // RL2: idle stop
    // RL4: async also obeys idle stop
    // RL10: sleep needs external, unsynchronised clock
    // RL16: RTC path meets the sleep condition only while sync select is zero (RL14)
    run_ok = s_q.run && !(cpu_idle && s_q.idle_stop)
             && (!cpu_sleep || (s_q.clk_src && !s_q.sync_sel));
    case (mode)
      // RL1: one step per cycle
      gtr_pkg::GTR_MODE_TIMER: inc = 1'b1;
      // RL5: cycles while gate high
      gtr_pkg::GTR_MODE_GATED: inc = gate_clock_pin;
      // RL3: synchronised rising edge
      gtr_pkg::GTR_MODE_SYNC:  inc = s_q.sync2 && !s_q.sync3;
      // RL4: raw rising edge
      gtr_pkg::GTR_MODE_ASYNC: inc = gate_clock_pin && !s_q.ext_prev;
      // RL13: oscillator rising edge
      gtr_pkg::GTR_MODE_RTC:   inc = lp_osc_in && !s_q.lp_prev;
      default:                 inc = 1'b0;
    endcase
    // RL7: divide by prescaler
    // A smaller prescale select must not leave the counter past its terminal value
    tick  = run_ok && inc && (s_q.psc >= psc_last(s_q.psc_sel));
    match = tick && (s_q.count == s_q.period);
  end

  always_comb begin
    s_d       = s_q;
    s_d.wake  = 1'b0;
    irq_set   = 3'b000;
    irq_clr   = 3'b000;

    // Only sync2 reads sync1
    s_d.sync1     = gate_clock_pin;
    s_d.sync2     = s_q.sync1;
    s_d.sync3     = s_q.sync2;
    s_d.ext_prev  = gate_clock_pin;
    s_d.lp_prev   = lp_osc_in;
    s_d.gate_prev = gate_clock_pin;

    // RL8: prescaler holds while off
    if (run_ok && inc) begin
      s_d.psc = tick ? 8'h00 : s_q.psc + 8'h01;
    end

    if (tick) begin
      // RL1: wrap at period
      s_d.count = match ? 16'h0000 : s_q.count + 16'h0001;
    end

    // RL11: sticky period flag
    if (match) begin
      irq_set[`GTR_IRQ_PERIOD] = 1'b1;
    end

    // RL15: carry-out wake event
    if (match && s_q.lposc_en) begin
      s_d.wake               = 1'b1;
      irq_set[`GTR_IRQ_WAKE] = 1'b1;
    end

    // RL6: gate falling edge flag, count kept
    if (mode == gtr_pkg::GTR_MODE_GATED && s_q.gate_prev && !gate_clock_pin) begin
      irq_set[`GTR_IRQ_GATE] = 1'b1;
    end

    // Write channels taken independently, either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_ok  = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end

    if (wr_en) begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `GTR_RESP_OKAY;
      case ({s_q.awaddr[7:2], 2'b00})
        `GTR_OFS_COUNT: begin
          // RL8: count write clears prescaler
          // RL9: only this write changes the count
          s_d.count = merge16(s_q.count, s_q.wdata, s_q.wstrb);
          // Prescaler clock halted while off, so it keeps its value then
          if (s_q.run) begin
            s_d.psc = 8'h00;
          end
        end
        `GTR_OFS_PERIOD: begin
          s_d.period = merge16(s_q.period, s_q.wdata, s_q.wstrb);
        end
        `GTR_OFS_CONTROL: begin
          if (s_q.wstrb[1]) begin
            s_d.run       = s_q.wdata[`GTR_BIT_RUN];
            s_d.idle_stop = s_q.wdata[`GTR_BIT_IDLE_STOP];
            // RL8: clearing run clears prescaler
            if (s_q.run && !s_q.wdata[`GTR_BIT_RUN]) begin
              s_d.psc = 8'h00;
            end
          end
          if (s_q.wstrb[0]) begin
            s_d.gate_en  = s_q.wdata[`GTR_BIT_GATE];
            s_d.psc_sel  = s_q.wdata[`GTR_BIT_PSC_HI:`GTR_BIT_PSC_LO];
            // RL14: software keeps this zero for the oscillator
            s_d.sync_sel = s_q.wdata[`GTR_BIT_SYNC];
            s_d.clk_src  = s_q.wdata[`GTR_BIT_CLK_SRC];
          end
        end
        `GTR_OFS_OSC_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.lposc_en = s_q.wdata[`GTR_BIT_LPOSC];
          end
        end
        `GTR_OFS_IRQ_STAT: begin
          // Status is read-to-clear; writes are ignored
        end
        `GTR_OFS_IRQ_MASK: begin
          if (s_q.wstrb[0]) begin
            s_d.mask = s_q.wdata[`GTR_IRQ_W-1:0];
          end
        end
        default: begin
          s_d.bresp = `GTR_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    if (rd_en) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `GTR_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        `GTR_OFS_COUNT:    s_d.rdata[15:0] = s_q.count;
        `GTR_OFS_PERIOD:   s_d.rdata[15:0] = s_q.period;
        `GTR_OFS_CONTROL:  s_d.rdata[15:0] = ctrl_word;
        `GTR_OFS_OSC_CTRL: s_d.rdata[`GTR_BIT_LPOSC] = s_q.lposc_en;
        `GTR_OFS_IRQ_STAT: begin
          s_d.rdata[`GTR_IRQ_W-1:0] = s_q.status;
          irq_clr                   = s_q.status;
        end
        `GTR_OFS_IRQ_MASK: s_d.rdata[`GTR_IRQ_W-1:0] = s_q.mask;
        default:           s_d.rresp = `GTR_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // RL11: a new event beats a clearing read
    s_d.status = (s_q.status & ~irq_clr) | irq_set;
    // RL12: enable gates the request
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.count   <= `GTR_RST_COUNT;
      s_q.period  <= `GTR_RST_PERIOD;
      s_q.bresp   <= `GTR_RESP_OKAY;
      s_q.rresp   <= `GTR_RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: tb/gtr_timer_asserts.sv
`timescale 1ns/10ps
module gtr_timer_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        wake_event
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read response");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during write response");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake event longer than one cycle");
  a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid || s_axi_rvalid)
    else $error("interrupt fell without software access");
  cover property (wake_event);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind gtr_timer gtr_timer_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq, .wake_event);

// File: tb/tb.sv
`timescale 1ns/10ps
`include "gtr_cfg.svh"
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, gate_clock_pin, lp_osc_in, cpu_idle, cpu_sleep, irq, wake_event;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  int          miscompares, checks, cycles, wakes, n;
  int          div[4] = '{1, 8, 64, 256};
  integer      seed;

  gtr_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_clock_pin, .lp_osc_in, .cpu_idle,
    .cpu_sleep, .irq, .wake_event);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    check({32'h0, s_axi_bresp}, {32'h0, `GTR_RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask

  // Expectation queued before the request goes out
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [15:0] v);
    exp_q.push_back({r, 16'h0000, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Counting window: idle stop holds the count outside it
  task automatic run_for(input int c);
    cpu_idle <= 1'b0;
    repeat (c) @(posedge aclk);
    cpu_idle <= 1'b1;
  endtask

  task automatic pulses(input int k, input logic osc);
    repeat (k) begin
      gate_clock_pin <= !osc;
      lp_osc_in <= osc;
      repeat (4) @(posedge aclk);
      gate_clock_pin <= 1'b0;
      lp_osc_in <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (wake_event === 1'b1) begin
      wakes++;
    end
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    seed = 32'hf3a8;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {gate_clock_pin, lp_osc_in, cpu_sleep} = 3'h0;
    cpu_idle = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`GTR_OFS_PERIOD, `GTR_RESP_OKAY, `GTR_RST_PERIOD);
    rd(8'h18, `GTR_RESP_SLVERR, 16'h0000);
    wr(`GTR_OFS_CONTROL, 16'ha000);
    wr(`GTR_OFS_PERIOD, 16'h0005);
    wr(`GTR_OFS_COUNT, 16'h0003);
    run_for(4);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0001);
    rd(`GTR_OFS_IRQ_STAT, `GTR_RESP_OKAY, 16'h0001);
    rd(`GTR_OFS_IRQ_STAT, `GTR_RESP_OKAY, 16'h0000);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0001);
    wr(`GTR_OFS_PERIOD, 16'hffff);
    for (int s = 0; s < 4; s++) begin
      wr(`GTR_OFS_CONTROL, 16'ha000 | 16'(s << 4));
      wr(`GTR_OFS_COUNT, 16'h0000);
      run_for(3 * div[s]);
      rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0003);
    end
    wr(`GTR_OFS_CONTROL, 16'ha010);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0003);
    run_for(5);
    wr(`GTR_OFS_COUNT, 16'h0000);
    run_for(7);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0000);
    wr(`GTR_OFS_CONTROL, 16'ha000);
    wr(`GTR_OFS_PERIOD, 16'h0001);
    run_for(2);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    wr(`GTR_OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    rd(`GTR_OFS_IRQ_STAT, `GTR_RESP_OKAY, 16'h0001);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    wr(`GTR_OFS_PERIOD, 16'hffff);
    cpu_idle <= 1'b0;
    wr(`GTR_OFS_CONTROL, 16'h8040);
    wr(`GTR_OFS_COUNT, 16'h0000);
    n = 5 + ($random(seed) & 15);
    gate_clock_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    gate_clock_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, n[15:0]);
    rd(`GTR_OFS_IRQ_STAT, `GTR_RESP_OKAY, 16'h0002);
    cpu_sleep <= 1'b1;
    wr(`GTR_OFS_CONTROL, 16'h8000);
    wr(`GTR_OFS_COUNT, 16'h0007);
    repeat (20) @(posedge aclk);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0007);
    wr(`GTR_OFS_CONTROL, 16'h8002);
    wr(`GTR_OFS_COUNT, 16'h0000);
    pulses(5, 1'b0);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0005);
    cpu_sleep <= 1'b0;
    wr(`GTR_OFS_CONTROL, 16'h8006);
    wr(`GTR_OFS_COUNT, 16'h0000);
    pulses(5, 1'b0);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0005);
    cpu_sleep <= 1'b1;
    pulses(3, 1'b0);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0005);
    wr(`GTR_OFS_OSC_CTRL, 16'h0002);
    wr(`GTR_OFS_CONTROL, 16'h8002);
    wr(`GTR_OFS_PERIOD, 16'h0002);
    wr(`GTR_OFS_COUNT, 16'h0000);
    pulses(4, 1'b1);
    pulses(2, 1'b0);
    rd(`GTR_OFS_COUNT, `GTR_RESP_OKAY, 16'h0001);
    rd(`GTR_OFS_IRQ_STAT, `GTR_RESP_OKAY, 16'h0005);
    check(34'(wakes), 34'h1);
    complete_run();
  end
endmodule
